// file: logic/pvcc_pkg.sv
// Package: constants, layout and types of the paravirtual common settings bank
package pvcc_pkg;

  // --------------------------------------------------------------------------
  // Sizes and identities
  // --------------------------------------------------------------------------
  localparam int          NUM_RINGS   = 4;
  localparam int          RING_IDX_W  = 2;
  localparam logic [15:0] MAX_DEPTH   = 16'h0100;
  localparam logic [63:0] OFFERED_FEATURES = 64'h0000_0005_0000_0000;
  localparam int          PACKED_BIT  = 34;

  // --------------------------------------------------------------------------
  // Capability chain in configuration space
  // --------------------------------------------------------------------------
  localparam logic [7:0]  CAP_ID_VNDR   = 8'h09;
  localparam int          CAP_BASE_WORD = 16;
  localparam int          LOC_WORDS     = 5;
  localparam int          NUM_LOCS      = 4;
  localparam int          NOTIFY_LOC    = 1;
  localparam logic [7:0]  TYPE_COMMON   = 8'h01;
  localparam logic [7:0]  TYPE_NOTIFY   = 8'h02;
  localparam logic [7:0]  type_irq_cause = 8'h03;
  localparam logic [7:0]  TYPE_DEVICE   = 8'h04;
  localparam logic [7:0]  TYPE_WINDOW   = 8'h05;
  localparam logic [7:0]  REGION_MAX    = 8'h05;
  localparam logic [7:0]  LOC_TYPE [NUM_LOCS] = '{TYPE_COMMON, TYPE_NOTIFY,
                                                   type_irq_cause, TYPE_DEVICE};
  localparam logic [7:0]  LOC_LEN  [NUM_LOCS] = '{8'h10, 8'h14, 8'h10, 8'h10};
  localparam logic [7:0]  LOC_BAR  [NUM_LOCS] = '{8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [31:0] LOC_OFF  [NUM_LOCS] = '{32'h0000_0000, 32'h0000_0100,
                                                   32'h0000_0200, 32'h0000_0300};
  localparam logic [31:0] LOC_SIZE [NUM_LOCS] = '{32'h0000_0038, 32'h0000_0010,
                                                   32'h0000_0004, 32'h0000_0100};
  localparam logic [31:0] NOTIFY_MULT = 32'h0000_0004;

  // --------------------------------------------------------------------------
  // Common settings word map (word index = byte offset / 4)
  // --------------------------------------------------------------------------
  localparam logic [3:0] W_OFF_SEL  = 4'h0;
  localparam logic [3:0] W_OFF_CAP  = 4'h1;
  localparam logic [3:0] W_ACC_SEL  = 4'h2;
  localparam logic [3:0] W_ACC_CAP  = 4'h3;
  localparam logic [3:0] W_VEC_CNT  = 4'h4;
  localparam logic [3:0] W_STATE    = 4'h5;
  localparam logic [3:0] W_DEPTH    = 4'h6;
  localparam logic [3:0] W_ACTIVE   = 4'h7;
  localparam logic [3:0] W_DESC_LO  = 4'h8;
  localparam logic [3:0] W_DESC_HI  = 4'h9;
  localparam logic [3:0] W_PROD_LO  = 4'hA;
  localparam logic [3:0] W_PROD_HI  = 4'hB;
  localparam logic [3:0] W_CONS_LO  = 4'hC;
  localparam logic [3:0] W_CONS_HI  = 4'hD;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  word;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pvcc_req_t;

  typedef struct packed {
    logic [31:0] off_sel;
    logic [31:0] acc_sel;
    logic [63:0] accepted;
    logic [15:0] cfg_vec;
    logic [7:0]  state;
    logic [15:0] ring_sel;
  } pvcc_cc_t;

  typedef struct packed {
    logic [15:0] depth;
    logic [15:0] vector;
    logic        active;
    logic [63:0] desc;
    logic [63:0] prod;
    logic [63:0] cons;
  } pvcc_ring_t;

  localparam pvcc_cc_t   CC_RESET   = '{default: '0};
  localparam pvcc_ring_t RING_RESET = '{depth: MAX_DEPTH, default: '0};

endpackage : pvcc_pkg

// file: logic/pvcc_common_cfg.sv
// Common settings register bank and capability locators of a paravirtual function
//
// Behaviour
// - Every locator's identifier byte reads 09h, the vendor-specific capability code.
// - Locator type codes: 1 common, 2 doorbell, 3 cause, 4 device, 5 window.
// - Region selector holds 0 to 5, naming a base address register from 10h.
// - Byte length covers the whole locator including trailing extra data.
// - Locators of one type are chained most preferred first.
// - Offered word shows feature bits from bank index times 32; others read zero.
// - Accepted word returns written bits that are also offered.
// - Writing zero to lifecycle state resets the device; it then reads zero.
// - Epoch changes after a read of changed device settings, via change flag.
// - Ring depth reads maximum after reset and zero for unavailable index.
// - Without packed ring, ring depth only presents zero or a power of two.
// - Ring active gates request execution, one enabled, zero after reset.
// - At least one common locator exists, with a 4-byte aligned offset.
// - Doorbell slot index is a scaled index, not a byte offset; rings here hold no doorbell slot index.
// - Each ring holds descriptor, producer and consumer area addresses.
// - Fields are little-endian; 64-bit fields are independent low and high words.
`timescale 1ns/10ps
`default_nettype none

module pvcc_common_cfg (
  // Clock and reset
  input  wire logic                            CORE_CLK,
  input  wire logic                            RST_B,
  // Common settings region access
  input  wire pvcc_pkg::pvcc_req_t             COM_REQ,
  output logic [31:0]                          COM_RDATA,
  output logic                                 COM_RVALID,
  // Capability chain reads
  input  wire logic                            CFG_RD,
  input  wire logic [5:0]                      CFG_WORD,
  output logic [31:0]                          CFG_RDATA,
  output logic                                 CFG_RVALID,
  // Device-specific settings events
  input  wire logic                            DEV_CFG_CHG,
  input  wire logic                            DEV_CFG_RD,
  // Ring gates, functional reset and lifecycle state
  output logic [pvcc_pkg::NUM_RINGS-1:0]       RING_ACTIVE,
  output logic                                 DEV_RESET,
  output logic [7:0]                           LIFECYCLE
);
  import pvcc_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] merge32(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction : merge32

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  be);
    logic [15:0] r;
    r = old_v;
    if (be[0])
      r[7:0] = new_v[7:0];
    if (be[1])
      r[15:8] = new_v[15:8];
    return r;
  endfunction : merge16

  function automatic logic pow2z(input logic [15:0] v);
    return (v & (v - 16'h0001)) == 16'h0000;
  endfunction : pow2z

  function automatic logic [31:0] cap_word(input logic [5:0] w);
    logic [31:0] d;
    logic [7:0]  nxt;
    int          base;
    d = 32'h0000_0000;
    for (int k = 0; k < NUM_LOCS; k++)
    begin
      base = CAP_BASE_WORD + k * LOC_WORDS;
      nxt  = (k == NUM_LOCS - 1) ? 8'h00 : 8'((base + LOC_WORDS) * 4);
      if (w == 6'(base))
        d = {LOC_TYPE[k], LOC_LEN[k], nxt, CAP_ID_VNDR};
      else if (w == 6'(base + 1))
        d = {24'h00_0000, LOC_BAR[k]};
      else if (w == 6'(base + 2))
        d = LOC_OFF[k];
      else if (w == 6'(base + 3))
        d = LOC_SIZE[k];
      else if (w == 6'(base + 4) && k == NOTIFY_LOC)
        d = NOTIFY_MULT;
    end
    return d;
  endfunction : cap_word

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  pvcc_cc_t                cc_r, cc_nxt;
  pvcc_ring_t              rings_r [NUM_RINGS];
  pvcc_ring_t              rings_nxt [NUM_RINGS];
  logic [7:0]              epoch_r, epoch_nxt;
  logic                    chg_r, chg_nxt;
  logic [31:0]             com_rdata_r, com_rdata_nxt;
  logic                    com_rvalid_r, com_rvalid_nxt;
  logic [31:0]             cfg_rdata_r, cfg_rdata_nxt;
  logic                    cfg_rvalid_r, cfg_rvalid_nxt;
  logic                    dev_reset_r, dev_reset_nxt;
  logic                    ring_ok;
  logic [RING_IDX_W-1:0]   ridx;
  logic                    packed_ring;
  pvcc_ring_t              cur;
  logic [15:0]             depth_w;

  assign ring_ok     = cc_r.ring_sel < 16'(NUM_RINGS);
  assign ridx        = cc_r.ring_sel[RING_IDX_W-1:0];
  assign packed_ring = cc_r.accepted[PACKED_BIT];
  assign cur         = ring_ok ? rings_r[ridx] : '0;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    cc_nxt         = cc_r;
    rings_nxt      = rings_r;
    epoch_nxt      = epoch_r;
    chg_nxt        = chg_r | DEV_CFG_CHG;
    dev_reset_nxt  = 1'b0;
    depth_w        = merge16(cur.depth, COM_REQ.wdata[15:0], COM_REQ.be[1:0]);
    cfg_rvalid_nxt = CFG_RD;
    cfg_rdata_nxt  = CFG_RD ? cap_word(CFG_WORD) : 32'h0000_0000;
    com_rvalid_nxt = COM_REQ.rd;
    com_rdata_nxt  = 32'h0000_0000;

    // Epoch bumps only when a changed value is actually read
    if (DEV_CFG_RD && chg_r)
    begin
      epoch_nxt = epoch_r + 8'h01;
      chg_nxt   = DEV_CFG_CHG;
    end

    if (COM_REQ.rd)
    begin
      case (COM_REQ.word)
        W_OFF_SEL: com_rdata_nxt = cc_r.off_sel;
        W_OFF_CAP: com_rdata_nxt = (cc_r.off_sel < 32'h2) ?
                     OFFERED_FEATURES[cc_r.off_sel[0]*32 +: 32] : 32'h0;
        W_ACC_SEL: com_rdata_nxt = cc_r.acc_sel;
        W_ACC_CAP: com_rdata_nxt = (cc_r.acc_sel < 32'h2) ?
                     cc_r.accepted[cc_r.acc_sel[0]*32 +: 32] : 32'h0;
        W_VEC_CNT: com_rdata_nxt = {16'(NUM_RINGS), cc_r.cfg_vec};
        W_STATE:   com_rdata_nxt = {cc_r.ring_sel, epoch_r, cc_r.state};
        W_DEPTH:   com_rdata_nxt = {cur.vector, cur.depth};
        W_ACTIVE:  com_rdata_nxt = {(ring_ok ? cc_r.ring_sel : 16'h0),
                                    15'h0000, cur.active};
        W_DESC_LO: com_rdata_nxt = cur.desc[31:0];
        W_DESC_HI: com_rdata_nxt = cur.desc[63:32];
        W_PROD_LO: com_rdata_nxt = cur.prod[31:0];
        W_PROD_HI: com_rdata_nxt = cur.prod[63:32];
        W_CONS_LO: com_rdata_nxt = cur.cons[31:0];
        W_CONS_HI: com_rdata_nxt = cur.cons[63:32];
        default:   com_rdata_nxt = 32'h0000_0000;
      endcase
    end

    if (COM_REQ.wr)
    begin
      case (COM_REQ.word)
        W_OFF_SEL: cc_nxt.off_sel = merge32(cc_r.off_sel, COM_REQ.wdata, COM_REQ.be);
        W_ACC_SEL: cc_nxt.acc_sel = merge32(cc_r.acc_sel, COM_REQ.wdata, COM_REQ.be);
        W_ACC_CAP:
        begin
          // Bits never offered are dropped
          if (cc_r.acc_sel < 32'h2)
            cc_nxt.accepted[cc_r.acc_sel[0]*32 +: 32] =
              merge32(cc_r.accepted[cc_r.acc_sel[0]*32 +: 32], COM_REQ.wdata,
                      COM_REQ.be) & OFFERED_FEATURES[cc_r.acc_sel[0]*32 +: 32];
        end
        W_VEC_CNT: cc_nxt.cfg_vec = merge16(cc_r.cfg_vec, COM_REQ.wdata[15:0],
                                            COM_REQ.be[1:0]);
        W_STATE:
        begin
          if (COM_REQ.be[0])
            cc_nxt.state = COM_REQ.wdata[7:0];
          if (COM_REQ.be[3:2] != 2'b00)
            cc_nxt.ring_sel = merge16(cc_r.ring_sel, COM_REQ.wdata[31:16],
                                      COM_REQ.be[3:2]);
        end
        W_DEPTH:
        begin
          if (ring_ok && COM_REQ.be[1:0] != 2'b00 && depth_w <= MAX_DEPTH &&
              (packed_ring || pow2z(depth_w)))
            rings_nxt[ridx].depth = depth_w;
          if (ring_ok)
            rings_nxt[ridx].vector = merge16(cur.vector, COM_REQ.wdata[31:16],
                                             COM_REQ.be[3:2]);
        end
        W_ACTIVE:
        begin
          if (ring_ok && COM_REQ.be[0])
            rings_nxt[ridx].active = COM_REQ.wdata[0];
        end
        W_DESC_LO: if (ring_ok) rings_nxt[ridx].desc[31:0] =
                     merge32(cur.desc[31:0], COM_REQ.wdata, COM_REQ.be);
        W_DESC_HI: if (ring_ok) rings_nxt[ridx].desc[63:32] =
                     merge32(cur.desc[63:32], COM_REQ.wdata, COM_REQ.be);
        W_PROD_LO: if (ring_ok) rings_nxt[ridx].prod[31:0] =
                     merge32(cur.prod[31:0], COM_REQ.wdata, COM_REQ.be);
        W_PROD_HI: if (ring_ok) rings_nxt[ridx].prod[63:32] =
                     merge32(cur.prod[63:32], COM_REQ.wdata, COM_REQ.be);
        W_CONS_LO: if (ring_ok) rings_nxt[ridx].cons[31:0] =
                     merge32(cur.cons[31:0], COM_REQ.wdata, COM_REQ.be);
        W_CONS_HI: if (ring_ok) rings_nxt[ridx].cons[63:32] =
                     merge32(cur.cons[63:32], COM_REQ.wdata, COM_REQ.be);
        default: ;
      endcase

      // Zero into lifecycle state clears the bank and every ring (depth back to maximum) in one cycle, keeping the epoch and change flag
      if (COM_REQ.word == W_STATE && COM_REQ.be[0] && COM_REQ.wdata[7:0] == 8'h00)
      begin
        cc_nxt        = CC_RESET;
        dev_reset_nxt = 1'b1;
        for (int q = 0; q < NUM_RINGS; q++)
          rings_nxt[q] = RING_RESET;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cc_r         <= CC_RESET;
      epoch_r      <= 8'h00;
      chg_r        <= 1'b0;
      com_rdata_r  <= 32'h0000_0000;
      com_rvalid_r <= 1'b0;
      cfg_rdata_r  <= 32'h0000_0000;
      cfg_rvalid_r <= 1'b0;
      dev_reset_r  <= 1'b0;
      for (int q = 0; q < NUM_RINGS; q++)
        rings_r[q] <= RING_RESET;
    end
    else
    begin
      cc_r         <= cc_nxt;
      epoch_r      <= epoch_nxt;
      chg_r        <= chg_nxt;
      com_rdata_r  <= com_rdata_nxt;
      com_rvalid_r <= com_rvalid_nxt;
      cfg_rdata_r  <= cfg_rdata_nxt;
      cfg_rvalid_r <= cfg_rvalid_nxt;
      dev_reset_r  <= dev_reset_nxt;
      for (int q = 0; q < NUM_RINGS; q++)
        rings_r[q] <= rings_nxt[q];
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign COM_RDATA  = com_rdata_r;
  assign COM_RVALID = com_rvalid_r;
  assign CFG_RDATA  = cfg_rdata_r;
  assign CFG_RVALID = cfg_rvalid_r;
  assign DEV_RESET  = dev_reset_r;
  assign LIFECYCLE  = cc_r.state;

  for (genvar g = 0; g < NUM_RINGS; g++)
  begin : g_gate
    assign RING_ACTIVE[g] = rings_r[g].active;
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic rec_head;
  logic rec_bar;
  assign rec_head = ((int'(CFG_WORD) - CAP_BASE_WORD) % LOC_WORDS == 0) &&
                    (int'(CFG_WORD) >= CAP_BASE_WORD) &&
                    (int'(CFG_WORD) < CAP_BASE_WORD + NUM_LOCS * LOC_WORDS);
  assign rec_bar  = ((int'(CFG_WORD) - CAP_BASE_WORD) % LOC_WORDS == 1) &&
                    (int'(CFG_WORD) >= CAP_BASE_WORD) &&
                    (int'(CFG_WORD) < CAP_BASE_WORD + NUM_LOCS * LOC_WORDS);

  property p_cap_id;
    @(posedge CORE_CLK) disable iff (!rst_n)
      CFG_RD && rec_head |=> CFG_RVALID && CFG_RDATA[7:0] == CAP_ID_VNDR;
  endproperty
  a_cap_id: assert property (p_cap_id) else $error("locator id byte wrong");

  property p_cap_type;
    @(posedge CORE_CLK) disable iff (!rst_n)
      CFG_RD && rec_head |=> CFG_RDATA[31:24] >= TYPE_COMMON &&
                             CFG_RDATA[31:24] <= TYPE_WINDOW;
  endproperty
  a_cap_type: assert property (p_cap_type) else $error("locator type reserved");

  property p_cap_bar;
    @(posedge CORE_CLK) disable iff (!rst_n)
      CFG_RD && rec_bar |=> CFG_RDATA[7:0] <= REGION_MAX && CFG_RDATA[31:8] == 24'h0;
  endproperty
  a_cap_bar: assert property (p_cap_bar) else $error("region selector reserved");

  property p_offered;
    @(posedge CORE_CLK) disable iff (!rst_n)
      COM_REQ.rd && COM_REQ.word == W_OFF_CAP && cc_r.off_sel > 32'h1
        |=> COM_RVALID && COM_RDATA == 32'h0;
  endproperty
  a_offered: assert property (p_offered) else $error("high offered bank not zero");

  property p_accepted;
    @(posedge CORE_CLK) disable iff (!rst_n)
      COM_REQ.wr && COM_REQ.word == W_ACC_CAP
        |=> (cc_r.accepted & ~OFFERED_FEATURES) == 64'h0;
  endproperty
  a_accepted: assert property (p_accepted) else $error("unoffered bit accepted");

  property p_reset;
    @(posedge CORE_CLK) disable iff (!rst_n)
      COM_REQ.wr && COM_REQ.word == W_STATE && COM_REQ.be[0] &&
      COM_REQ.wdata[7:0] == 8'h00
        |=> DEV_RESET && LIFECYCLE == 8'h00 && RING_ACTIVE == '0 ##1 !DEV_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("functional reset incomplete");

  property p_epoch;
    @(posedge CORE_CLK) disable iff (!rst_n)
      DEV_CFG_RD && chg_r |=> epoch_r == $past(epoch_r) + 8'h01;
  endproperty
  a_epoch: assert property (p_epoch) else $error("epoch did not advance");

  property p_unavail;
    @(posedge CORE_CLK) disable iff (!rst_n)
      COM_REQ.rd && COM_REQ.word == W_DEPTH && !ring_ok |=> COM_RDATA[15:0] == 16'h0;
  endproperty
  a_unavail: assert property (p_unavail) else $error("absent ring depth nonzero");

  property p_pow2;
    @(posedge CORE_CLK) disable iff (!rst_n)
      !packed_ring |-> pow2z(cur.depth);
  endproperty
  a_pow2: assert property (p_pow2) else $error("ring depth not power of two");

endmodule : pvcc_common_cfg

`default_nettype wire

// file: tb/pvcc_host_model.sv
// Host driver model: register reads and writes, capability reads
`timescale 1ns/10ps
`default_nettype none
module pvcc_host_model
  import pvcc_pkg::*;
(
  // Clock and answers
  input  wire logic        clk,
  input  wire logic [31:0] com_rdata,
  input  wire logic        com_rvalid,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rvalid,
  // Requests
  output pvcc_req_t        req,
  output logic             cfg_rd,
  output logic [5:0]       cfg_word
);
  int tmo = 0;
  initial
  begin
    req = '0;
    cfg_rd = 1'b0;
    cfg_word = 6'h00;
  end
  // Common words only; never locator fields or read-only words
  task automatic wr(input logic [3:0] w, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk) #1;
    req = '{wr: 1'b1, rd: 1'b0, word: w, be: be, wdata: d};
    @(posedge clk) #1;
    req = '0;
  endtask : wr
  task automatic rd(input logic [3:0] w, output logic [31:0] d);
    @(posedge clk) #1;
    req = '{wr: 1'b0, rd: 1'b1, word: w, be: 4'hF, wdata: 32'h0};
    @(posedge clk) #1;
    req = '0;
    if (com_rvalid !== 1'b1) tmo++;
    d = com_rdata;
  endtask : rd
  // Reads only the locator dwords it needs
  task automatic cfg(input logic [5:0] w, output logic [31:0] d);
    @(posedge clk) #1;
    cfg_rd = 1'b1;
    cfg_word = w;
    @(posedge clk) #1;
    cfg_rd = 1'b0;
    if (cfg_rvalid !== 1'b1) tmo++;
    d = cfg_rdata;
  endtask : cfg
endmodule : pvcc_host_model
`default_nettype wire

// file: tb/paravirt_pci_capability_common_config_tb_top.sv
// Testbench: register bank against a bench model
`timescale 1ns/10ps
`default_nettype none
module paravirt_pci_capability_common_config_tb_top;
  import pvcc_pkg::*;
  logic                 CORE_CLK = 1'b0;
  logic                 RST_B = 1'b0;
  logic                 DEV_CFG_CHG = 1'b0;
  logic                 DEV_CFG_RD = 1'b0;
  pvcc_req_t            COM_REQ;
  logic [31:0]          COM_RDATA, CFG_RDATA, d, e, v;
  logic                 COM_RVALID, CFG_RVALID, CFG_RD, DEV_RESET;
  logic [5:0]           CFG_WORD;
  logic [NUM_RINGS-1:0] RING_ACTIVE;
  logic [7:0]           LIFECYCLE, epoch;
  logic [31:0]          m_adr [5][6];
  logic [15:0]          m_dep [5], m_vec [5];
  int                   n_mismatch = 0, comparisons = 0, i, k, r;
  always #20 CORE_CLK = ~CORE_CLK;
  pvcc_common_cfg dut_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .COM_REQ(COM_REQ),
    .COM_RDATA(COM_RDATA), .COM_RVALID(COM_RVALID), .CFG_RD(CFG_RD), .CFG_WORD(CFG_WORD),
    .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID), .DEV_CFG_CHG(DEV_CFG_CHG),
    .DEV_CFG_RD(DEV_CFG_RD), .RING_ACTIVE(RING_ACTIVE), .DEV_RESET(DEV_RESET),
    .LIFECYCLE(LIFECYCLE));
  pvcc_host_model hm_u (.clk(CORE_CLK), .com_rdata(COM_RDATA), .com_rvalid(COM_RVALID),
    .cfg_rdata(CFG_RDATA), .cfg_rvalid(CFG_RVALID), .req(COM_REQ), .cfg_rd(CFG_RD),
    .cfg_word(CFG_WORD));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic pulse(input logic chg, input logic rd);
    @(posedge CORE_CLK) #1;
    DEV_CFG_CHG = chg;
    DEV_CFG_RD = rd;
    @(posedge CORE_CLK) #1;
    DEV_CFG_CHG = 1'b0;
    DEV_CFG_RD = 1'b0;
  endtask : pulse
  task automatic results;
    n_mismatch += hm_u.tmo;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    n_mismatch++;
    results();
  end
  initial
  begin
    void'($urandom(46));
    repeat (10) @(posedge CORE_CLK);
    #1 RST_B = 1'b1;
    repeat (3) @(posedge CORE_CLK);
    for (i = 0; i < NUM_LOCS * 4; i++)
    begin
      hm_u.cfg(6'(CAP_BASE_WORD + (i / 4) * LOC_WORDS + i % 4), d);
      k = i / 4;
      e = (i % 4 == 0) ? {8'(k + 1), LOC_LEN[k],
            (k < NUM_LOCS - 1) ? 8'(4 * (CAP_BASE_WORD + (k + 1) * LOC_WORDS)) : 8'h00,
            8'h09} : (i % 4 == 1) ? 32'h0 :
          (i % 4 == 2) ? LOC_OFF[k] : LOC_SIZE[k];
      cmp(d, e);
    end
    hm_u.cfg(6'(CAP_BASE_WORD + NOTIFY_LOC * LOC_WORDS + 4), d);
    cmp(d, NOTIFY_MULT);
    $display("Test locators done");
    hm_u.rd(W_DEPTH, d);
    cmp(d, {16'h0, MAX_DEPTH});
    hm_u.rd(W_ACTIVE, d);
    cmp(d, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      k = (i == 2) ? 2 + $urandom % 100 : i;
      hm_u.wr(W_OFF_SEL, 4'hF, 32'(k));
      hm_u.rd(W_OFF_CAP, d);
      cmp(d, k < 2 ? OFFERED_FEATURES[k*32 +: 32] : 32'h0);
      e = $urandom;
      hm_u.wr(W_ACC_SEL, 4'hF, 32'(k));
      hm_u.wr(W_ACC_CAP, 4'hF, e);
      hm_u.rd(W_ACC_CAP, d);
      cmp(d, k < 2 ? e & OFFERED_FEATURES[k*32 +: 32] : 32'h0);
    end
    hm_u.wr(W_ACC_SEL, 4'hF, 32'h1);
    hm_u.wr(W_ACC_CAP, 4'hF, 32'h0);
    v = $urandom;
    hm_u.wr(W_VEC_CNT, 4'h3, v);
    hm_u.rd(W_VEC_CNT, d);
    cmp(d, {16'(NUM_RINGS), v[15:0]});
    $display("Test features done");
    for (r = 0; r < 5; r++)
    begin
      hm_u.wr(W_STATE, 4'hC, 32'(r) << 16);
      v = $urandom;
      m_dep[r] = r < NUM_RINGS ? 16'h1 << (r + 4) : 16'h0;
      m_vec[r] = r < NUM_RINGS ? v[31:16] : 16'h0;
      hm_u.wr(W_DEPTH, 4'hF, {v[31:16], 16'h1 << (r + 4)});
      hm_u.wr(W_DEPTH, 4'h3, 32'h3);
      for (k = 0; k < 6; k++)
      begin
        m_adr[r][k] = $urandom;
        hm_u.wr(4'(W_DESC_LO + k), 4'hF, m_adr[r][k]);
        if (r == NUM_RINGS) m_adr[r][k] = 32'h0;
      end
      hm_u.wr(W_ACTIVE, 4'h1, 32'h1);
    end
    for (r = 0; r < 5; r++)
    begin
      hm_u.wr(W_STATE, 4'hC, 32'(r) << 16);
      hm_u.rd(W_DEPTH, d);
      cmp(d, {m_vec[r], m_dep[r]});
      hm_u.rd(W_ACTIVE, d);
      cmp(d, r < NUM_RINGS ? {16'(r), 16'h1} : 32'h0);
      for (k = 0; k < 6; k++)
      begin
        hm_u.rd(4'(W_DESC_LO + k), d);
        cmp(d, m_adr[r][k]);
      end
    end
    cmp(32'(RING_ACTIVE), 32'hF);
    $display("Test rings done");
    hm_u.rd(W_STATE, d);
    epoch = d[15:8];
    pulse(1'b0, 1'b1);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    pulse(1'b0, 1'b1);
    hm_u.wr(W_STATE, 4'h2, 32'h0000_5500);
    hm_u.rd(W_STATE, d);
    cmp(32'(d[15:8]), 32'(epoch + 8'h01));
    $display("Test epoch done");
    hm_u.wr(W_STATE, 4'h1, 32'h0F);
    cmp(32'(LIFECYCLE), 32'h0F);
    hm_u.rd(W_STATE, d);
    cmp({24'h0, d[7:0]}, 32'h0F);
    hm_u.wr(W_STATE, 4'h1, 32'h0);
    cmp(32'(DEV_RESET), 32'h1);
    cmp(32'(LIFECYCLE), 32'h0);
    hm_u.rd(W_STATE, d);
    cmp(d, 32'(epoch + 8'h01) << 8);
    cmp(32'(RING_ACTIVE), 32'h0);
    cmp(32'(DEV_RESET), 32'h0);
    hm_u.rd(W_DEPTH, d);
    cmp(d, {16'h0, MAX_DEPTH});
    hm_u.rd(W_VEC_CNT, d);
    cmp(d, {16'(NUM_RINGS), 16'h0});
    $display("Test functional reset done");
    results();
  end
endmodule : paravirt_pci_capability_common_config_tb_top
`default_nettype wire
